// ### hdl/ctm_pkg.sv
// package: constants and carrier types for the compact timer modes block
package ctm_pkg;
   // ==========================================================
   // modes and pin actions
   localparam logic [1:0] CTM_MODE_CMP = 2'h0;
   localparam logic [1:0] CTM_MODE_PWM = 2'h2;
   localparam logic [1:0] CTM_MODE_TMR = 2'h3;
   localparam logic [1:0] CTM_IO_NONE = 2'h0;
   localparam logic [1:0] CTM_IO_LOW = 2'h1;
   localparam logic [1:0] CTM_IO_HIGH = 2'h2;
   localparam logic [1:0] CTM_IO_TOGGLE = 2'h3;
   localparam logic [1:0] CTM_PWM_INACT = 2'h0;
   localparam logic [1:0] CTM_PWM_ACT = 2'h1;
   localparam logic [1:0] CTM_PWM_WAVE = 2'h2;
   // ==========================================================
   // widths and reset values
   localparam int CTM_CNT_W = 10;
   localparam int CTM_P_W = 3;
   localparam int CTM_P_SHIFT = 7;
   localparam logic [9:0] CTM_CNT_MAX = 10'h3ff;
   localparam logic [9:0] CTM_CNT_RST = 10'h000;
   localparam logic [2:0] CTM_P_ZERO = 3'h0;
   localparam logic [9:0] CTM_A_ZERO = 10'h000;
   localparam logic CTM_PIN_RST = 1'b0;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [1:0] mode_select;
      logic [1:0] pin_action;
      logic output_level_control;
      logic output_invert;
      logic period_duty_swap;
      logic clear_source_select;
   } ctm_ctrl_t;

   typedef struct packed {
      logic [9:0] count;
      logic on_q;
      logic pin;
      logic pwm_act;
      logic match_a_flag;
      logic match_p_flag;
      logic hit_a;
      logic hit_p;
   } ctm_state_t;
endpackage : ctm_pkg

// ### hdl/ctm_reset_sync.sv
// file: two-stage release synchroniser for the asynchronous reset
`timescale 1ns/1ps
module ctm_reset_sync (
   // clock and raw reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // released copy
   output logic rst_n_o
);
   logic stage;

   // ==========================================================
   // assert at once, release after two edges
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stage <= 1'b0;
         rst_n_o <= 1'b0;
      end else begin
         stage <= 1'b1;
         rst_n_o <= stage;
      end
   end
endmodule : ctm_reset_sync

// ### hdl/ctm_timer.sv
// file: compact timer mode logic (compare, timer/counter, pwm)
// Function
// RL1: mode 00 compare, 10 pwm, 11 timer
// RL2: clear on P match, or wrap at P=0
// RL3: clear-select low raises both flags
// RL4: clear-select high: A clears, only A flag
// RL5: A zero with select high wraps, no flag
// RL6: compare pin changes only on A match
// RL7: pin action sets, clears, toggles or holds
// RL8: counter-on rise loads initial pin level
// RL9: timer mode as compare, pin untouched
// RL10: pwm ignores clear-select, period comparator clears
// RL11: swap bit picks period and duty comparator
// RL12: swap 0: period P times 128, duty A
// RL13: swap 1: period A, duty P times 128
// RL14: duty not below period gives full duty
// RL15: pwm raises both match flags
// RL16: pin action passes pwm or forces level
// RL17: invert bit reverses pwm pin polarity
// RL18: counting continues while pin is forced
// RL19: on-rise zeroes counter, fall holds count
// RL20: P compares top three counter bits
// RL21: software stops timer before mode changes
// RL22: pwm active from clear until duty reached
// RL23: flags sticky, one set per match
`timescale 1ns/1ps
module ctm_timer
   import ctm_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // timer clock tick and control
   input wire logic tick_i,
   input wire logic counter_on_i,
   input wire ctm_ctrl_t ctrl_i,
   input wire logic [9:0] compare_a_value_i,
   input wire logic [2:0] compare_p_value_i,
   // flag clears from software
   input wire logic clear_a_flag_i,
   input wire logic clear_p_flag_i,
   // status and pin
   output logic [9:0] count_o,
   output logic match_a_flag_o,
   output logic match_p_flag_o,
   output logic pin_o,
   output logic pin_oe_o
);
   logic rst_n;
   ctm_state_t st;
   ctm_state_t next_st;
   logic next_oe;

   ctm_reset_sync u_rst (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .rst_n_o(rst_n)
   );

   // ==========================================================
   // comparators
   function automatic logic p_eq(input logic [9:0] c, input logic [2:0] p);
      p_eq = (c[9:7] == p) && (c[6:0] == 7'h00); // RL20
   endfunction : p_eq

   function automatic logic [10:0] p_span(input logic [2:0] p);
      p_span = (p == CTM_P_ZERO) ? 11'h400 : {1'b0, p, 7'h00}; // RL12
   endfunction : p_span

   logic run;
   logic pwm_mode;
   logic a_eq;
   logic p_match;
   logic clr;
   logic wrap;
   logic set_a;
   logic set_p;
   logic [10:0] period;
   logic [10:0] duty;
   logic [10:0] cnt_nx;

   always_comb begin
      next_st = st;
      run = counter_on_i && st.on_q && tick_i;
      pwm_mode = (ctrl_i.mode_select == CTM_MODE_PWM); // RL1
      a_eq = (st.count == compare_a_value_i);
      p_match = p_eq(st.count, compare_p_value_i);
      wrap = (st.count == CTM_CNT_MAX);
      set_a = 1'b0;
      set_p = 1'b0;
      clr = 1'b0;
      period = 11'h000;
      duty = 11'h000;
      cnt_nx = {1'b0, st.count} + 11'h001;
      if (pwm_mode) begin
         // RL10 RL11
         if (!ctrl_i.period_duty_swap) begin
            period = p_span(compare_p_value_i); // RL12
            duty = {1'b0, compare_a_value_i};
         end else begin
            period = (compare_a_value_i == CTM_A_ZERO) ? 11'h400
               : {1'b0, compare_a_value_i}; // RL13
            duty = p_span(compare_p_value_i);
         end
         clr = (cnt_nx >= period);
         // period comparator never sees its own value: the clear one
         // count early stands in for its match
         if (!ctrl_i.period_duty_swap) begin
            set_a = a_eq && (compare_a_value_i != CTM_A_ZERO); // RL15
            set_p = run && clr && (compare_p_value_i != CTM_P_ZERO);
         end else begin
            set_a = run && clr && (compare_a_value_i != CTM_A_ZERO);
            set_p = p_match && (compare_p_value_i != CTM_P_ZERO);
         end
      end else if (!ctrl_i.clear_source_select) begin
         set_a = a_eq && (compare_a_value_i != CTM_A_ZERO); // RL3
         set_p = p_match && (compare_p_value_i != CTM_P_ZERO);
         clr = set_p || wrap; // RL2
      end else begin
         set_a = a_eq && (compare_a_value_i != CTM_A_ZERO); // RL4 RL5
         clr = set_a || wrap;
      end
      // one event per match, even when the counter is stopped on it
      next_st.hit_a = set_a;
      next_st.hit_p = set_p;
      set_a = set_a && !st.hit_a && st.on_q; // RL23
      set_p = set_p && !st.hit_p && st.on_q;
      next_st.on_q = counter_on_i;
      if (counter_on_i && !st.on_q) begin
         next_st.count = CTM_CNT_RST; // RL19
         next_st.hit_a = 1'b0;
         next_st.hit_p = 1'b0;
         next_st.pwm_act = 1'b1;
         next_st.pin = ctrl_i.output_level_control; // RL8
      end else if (run) begin
         next_st.count = clr ? CTM_CNT_RST : cnt_nx[9:0]; // RL18
      end
      if (pwm_mode && counter_on_i && st.on_q) begin
         // RL22 RL14
         next_st.pwm_act = ({1'b0, next_st.count} < duty);
      end
      if (!pwm_mode && set_a && ctrl_i.mode_select == CTM_MODE_CMP) begin
         unique case (ctrl_i.pin_action) // RL6 RL7
            CTM_IO_NONE: next_st.pin = st.pin;
            CTM_IO_LOW: next_st.pin = 1'b0;
            CTM_IO_HIGH: next_st.pin = 1'b1;
            CTM_IO_TOGGLE: next_st.pin = !st.pin;
         endcase
      end
      // sticky flags: a set in the same cycle beats the clear
      next_st.match_a_flag = set_a || (st.match_a_flag && !clear_a_flag_i);
      next_st.match_p_flag = set_p || (st.match_p_flag && !clear_p_flag_i);
      next_oe = (ctrl_i.mode_select != CTM_MODE_TMR); // RL9
   end

   // ==========================================================
   // state register
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // pin drive, registered
   logic pwm_lvl;
   logic pin_nx;
   always_comb begin
      // active level follows the level bit, then the invert bit
      unique case (ctrl_i.pin_action) // RL16
         CTM_PWM_INACT: pwm_lvl = !ctrl_i.output_level_control;
         CTM_PWM_ACT: pwm_lvl = ctrl_i.output_level_control;
         default: pwm_lvl = next_st.pwm_act
            ? ctrl_i.output_level_control : !ctrl_i.output_level_control;
      endcase
      if (ctrl_i.mode_select == CTM_MODE_PWM) begin
         pin_nx = pwm_lvl ^ ctrl_i.output_invert; // RL17
      end else begin
         pin_nx = next_st.pin ^ ctrl_i.output_invert;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_o <= CTM_PIN_RST;
         pin_oe_o <= 1'b0;
         count_o <= CTM_CNT_RST;
         match_a_flag_o <= 1'b0;
         match_p_flag_o <= 1'b0;
      end else begin
         pin_o <= pin_nx;
         pin_oe_o <= next_oe;
         count_o <= next_st.count;
         match_a_flag_o <= next_st.match_a_flag;
         match_p_flag_o <= next_st.match_p_flag;
      end
   end

   // ==========================================================
   // checks
   flag_sticky_a: assert property ( // RL23
      @(posedge clock_i) disable iff (!rst_n)
      st.match_a_flag && !clear_a_flag_i |=> st.match_a_flag)
      else $error("a flag dropped without clear");

   flag_once_a: assert property ( // RL23
      @(posedge clock_i) disable iff (!rst_n)
      set_a |=> !set_a)
      else $error("a flag set twice for one match");

   set_wins_a: assert property ( // RL23
      @(posedge clock_i) disable iff (!rst_n)
      set_p |=> st.match_p_flag)
      else $error("p flag set lost to a clear");

   on_rise_a: assert property ( // RL19
      @(posedge clock_i) disable iff (!rst_n)
      counter_on_i && !st.on_q |=> st.count == CTM_CNT_RST)
      else $error("counter not zeroed on start");

   hold_off_a: assert property ( // RL19
      @(posedge clock_i) disable iff (!rst_n)
      !counter_on_i && st.on_q |=> $stable(st.count))
      else $error("count moved while off");

   no_pflag_a: assert property ( // RL4
      @(posedge clock_i) disable iff (!rst_n)
      ctrl_i.mode_select == CTM_MODE_CMP && ctrl_i.clear_source_select
      && !st.match_p_flag |=> !st.match_p_flag)
      else $error("p flag with a clear select");

   a_zero_a: assert property ( // RL5
      @(posedge clock_i) disable iff (!rst_n)
      !pwm_mode && compare_a_value_i == CTM_A_ZERO && !st.match_a_flag
      |=> !st.match_a_flag)
      else $error("a flag raised with a zero compare value");

   init_lvl_a: assert property ( // RL8
      @(posedge clock_i) disable iff (!rst_n)
      counter_on_i && !st.on_q
      |=> st.pin == $past(ctrl_i.output_level_control))
      else $error("initial pin level wrong");

   cmp_pin_a: assert property ( // RL6
      @(posedge clock_i) disable iff (!rst_n)
      ctrl_i.mode_select == CTM_MODE_CMP && !set_a
      && !(counter_on_i && !st.on_q) |=> $stable(st.pin))
      else $error("compare pin moved without an a match");

   p_clear_a: assert property ( // RL2
      @(posedge clock_i) disable iff (!rst_n)
      run && ctrl_i.mode_select == CTM_MODE_CMP && !ctrl_i.clear_source_select
      && set_p |=> st.count == CTM_CNT_RST)
      else $error("p match did not clear");

   wrap_a: assert property ( // RL5
      @(posedge clock_i) disable iff (!rst_n)
      run && st.count == CTM_CNT_MAX |=> st.count == CTM_CNT_RST)
      else $error("no wrap at maximum");

   p_top_a: assert property ( // RL20
      @(posedge clock_i) disable iff (!rst_n)
      set_p |-> st.count[6:0] == 7'h00 || cnt_nx[6:0] == 7'h00)
      else $error("p match off 128 grid");

   tmr_oe_a: assert property ( // RL9
      @(posedge clock_i) disable iff (!rst_n)
      ctrl_i.mode_select == CTM_MODE_TMR |=> !pin_oe_o)
      else $error("pin driven in timer mode");

   tmr_pin_a: assert property ( // RL9
      @(posedge clock_i) disable iff (!rst_n)
      ctrl_i.mode_select == CTM_MODE_TMR && !(counter_on_i && !st.on_q)
      |=> $stable(st.pin))
      else $error("pin level moved in timer mode");

   oe_on_a: assert property ( // RL9
      @(posedge clock_i) disable iff (!rst_n)
      ctrl_i.mode_select != CTM_MODE_TMR |=> pin_oe_o)
      else $error("pin not driven outside timer mode");

   pwm_clear_a: assert property ( // RL10
      @(posedge clock_i) disable iff (!rst_n)
      pwm_mode && run && clr |=> st.count == CTM_CNT_RST)
      else $error("pwm period did not clear the counter");

   pwm_start_a: assert property ( // RL22
      @(posedge clock_i) disable iff (!rst_n)
      pwm_mode && run && clr && duty != 11'h000 |=> st.pwm_act)
      else $error("pwm not active after a period clear");

   full_duty_a: assert property ( // RL14
      @(posedge clock_i) disable iff (!rst_n)
      pwm_mode && duty >= period && counter_on_i && st.on_q
      && $stable(ctrl_i) |=> st.pwm_act)
      else $error("full duty not held");

   // main scenarios
   cmp_pwm_c: cover property (@(posedge clock_i) pwm_mode && clr && run);
   cmp_af_c: cover property (@(posedge clock_i) set_a && !pwm_mode);
   cmp_pf_c: cover property (@(posedge clock_i) set_p);
   pwm_pf_c: cover property (@(posedge clock_i) pwm_mode && set_p);
   cnt_wrap_c: cover property (@(posedge clock_i) run && wrap);
endmodule : ctm_timer

// ### testbench/testbench.sv
// testbench: self-checking bench for the compact timer mode logic
`timescale 1ns/1ps
module testbench;
   import ctm_pkg::*;
   typedef struct packed {
      logic [13:0] val;
      logic [13:0] msk;
   } ctm_note_t;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic tick_i = 1'b1;
   logic on = 1'b0;
   ctm_ctrl_t ctrl = '0;
   ctm_ctrl_t c;
   logic [9:0] a_val = 10'h000;
   logic [2:0] p_val = 3'h0;
   logic clr_a = 1'b0;
   logic clr_p = 1'b0;
   logic [9:0] count_o;
   logic fa;
   logic fp;
   logic pin;
   logic oe;
   wire logic [13:0] obs = {count_o, fa, fp, pin, oe};
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   int per;
   int duty;
   ctm_note_t note_q[$];
   ctm_note_t n;
   logic [9:0] cnt;
   logic [1:0] act;
   logic ep;

   ctm_timer DUT (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .tick_i(tick_i),
      .counter_on_i(on), .ctrl_i(ctrl), .compare_a_value_i(a_val),
      .compare_p_value_i(p_val), .clear_a_flag_i(clr_a),
      .clear_p_flag_i(clr_p), .count_o(count_o), .match_a_flag_o(fa),
      .match_p_flag_o(fp), .pin_o(pin), .pin_oe_o(oe)
   );

   always #5 clock_i = ~clock_i;

   // ==========================================================
   // tasks
   task automatic results();
      if (err_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   task automatic check(input logic [13:0] seen, input logic [13:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic step(input int k);
      repeat (k) @(negedge clock_i);
   endtask : step

   // fields: count, then flag a, flag p, pin, enable
   task automatic note(input logic [9:0] v, input logic [3:0] f,
                       input logic [13:0] m);
      note_q.push_back('{{v, f}, m});
   endtask : note

   // ctrl changes only while the counter is off
   task automatic start(input ctm_ctrl_t s);
      on = 1'b0;
      step(1);
      ctrl = s;
      clr_a = 1'b1;
      clr_p = 1'b1;
      step(1);
      clr_a = 1'b0;
      clr_p = 1'b0;
      on = 1'b1;
      step(1);
   endtask : start

   // ==========================================================
   // watchdog and output monitor
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 10000) begin
         err_count++;
         results();
      end
   end

   initial forever begin
      @(negedge clock_i);
      #1;
      while (note_q.size() > 0) begin
         n = note_q.pop_front();
         check(obs & n.msk, n.val & n.msk);
      end
   end

   // ==========================================================
   // stimulus
   initial begin
      void'($urandom(32'hcdc0));
      step(16);
      arst_n_i = 1'b1;
      step(3);
      for (int i = 0; i < 8; i++) begin
         act = 2'(i >> 1);
         a_val = 10'h003;
         start('{CTM_MODE_CMP, act, i[0], 1'b0, 1'b0, 1'b0});
         note(10'h000, {2'b00, i[0], 1'b1}, 14'h3fff);
         step(4);
         ep = act == CTM_IO_NONE ? i[0] : act == CTM_IO_TOGGLE ? ~i[0] :
              act == CTM_IO_HIGH;
         note(10'h004, {2'b10, ep, 1'b1}, 14'h3fff);
      end
      a_val = 10'(5 + $urandom % 100);
      p_val = 3'h1;
      start('{CTM_MODE_CMP, CTM_IO_TOGGLE, 1'b0, 1'b0, 1'b0, 1'b0});
      step(int'(a_val) + 1);
      note(a_val + 10'h001, 4'b1011, 14'h3fff);
      step(128 - int'(a_val));
      note(10'h000, 4'b1111, 14'h3fff);
      step(4);
      note(10'h004, 4'b1111, 14'h3fff);
      on = 1'b0;
      step(3);
      note(10'h004, 4'b1111, 14'h3fff);
      clr_a = 1'b1;
      step(1);
      clr_a = 1'b0;
      note(10'h004, 4'b0111, 14'h3fff);
      a_val = 10'h0c8;
      start('{CTM_MODE_CMP, CTM_IO_HIGH, 1'b0, 1'b0, 1'b0, 1'b1});
      step(200);
      note(10'h0c8, 4'b0001, 14'h3fff);
      step(1);
      note(10'h000, 4'b1011, 14'h3fff);
      a_val = 10'h000;
      start(ctrl);
      step(1023);
      note(10'h3ff, 4'b0001, 14'h3fff);
      step(1);
      note(10'h000, 4'b0001, 14'h3fff);
      a_val = 10'h003;
      start('{CTM_MODE_TMR, CTM_IO_HIGH, 1'b1, 1'b0, 1'b0, 1'b0});
      step(4);
      note(10'h004, 4'b1000, 14'h3ffd);
      // pwm table: plain, full duty, inverted, forced active, forced idle
      for (int i = 0; i < 5; i++) begin
         a_val = 10'(1 + $urandom % 120);
         p_val = 3'h1;
         c = '{CTM_MODE_PWM, CTM_PWM_WAVE, ~i[0], 1'b0, 1'b0, 1'b0};
         if (i == 1) begin
            a_val = 10'h064;
            c.period_duty_swap = 1'b1;
         end
         if (i == 2) begin
            p_val = 3'h2;
            c.output_invert = 1'b1;
            c.clear_source_select = 1'b1;
         end
         if (i > 2) c.pin_action = i == 3 ? CTM_PWM_ACT : CTM_PWM_INACT;
         per = c.period_duty_swap ? int'(a_val) : int'(p_val) * 128;
         duty = c.period_duty_swap ? int'(p_val) * 128 : int'(a_val);
         start(c);
         cnt = 10'h000;
         repeat (400) begin
            tick_i = ($urandom % 4) != 0;
            step(1);
            if (tick_i) cnt = (int'(cnt) + 1 == per) ? 10'h000 : cnt + 10'h001;
            ep = c.pin_action == CTM_PWM_WAVE ? int'(cnt) < duty :
                 c.pin_action == CTM_PWM_ACT;
            ep = (ep ~^ c.output_level_control) ^ c.output_invert;
            note(cnt, {2'b00, ep, 1'b1}, 14'h3ff3);
         end
         tick_i = 1'b1;
         if (i != 1) note(10'h000, 4'b1100, 14'h000c);
      end
      step(2);
      results();
   end
endmodule : testbench
